// ===== dv/irb_core_model.sv
/*
  irb_core_model: processor-core stand-in issuing byte and single-bit
  accesses to the i/o register space, one request at a time.
  assumes: the bench launches every access through the acc task.
*/
`timescale 1ns/100ps
module irb_core_model (
  input  wire logic       clk,
  input  wire logic [7:0] io_rdata,
  input  wire logic       skip_taken,
  output logic      [5:0] io_addr,
  output logic      [7:0] io_wdata,
  output logic            io_we,
  output logic            io_rd,
  output logic            set_io_bit_instruction,
  output logic            clear_io_bit_instruction,
  output logic            skip_if_io_bit_set,
  output logic            skip_if_io_bit_clear,
  output logic      [2:0] io_bit
);
  // quiet bus from time zero
  initial begin
    {io_we, io_rd, set_io_bit_instruction, clear_io_bit_instruction} = 4'h0;
    {skip_if_io_bit_set, skip_if_io_bit_clear} = 2'h0;
    {io_addr, io_wdata, io_bit} = 17'h0_0000;
  end

  // op 0 write, 1 read, 2 bit set, 3 bit clear, 4 skip if set, 5 skip if clear
  task automatic acc(input int op, input logic [5:0] a, input logic [7:0] d, input logic [7:0] m,
                     input logic [2:0] b, output logic [7:0] q, output logic sk);
    @(posedge clk);
    io_addr <= a;
    io_wdata <= d & m;
    io_bit <= b;
    io_we <= op == 0;
    io_rd <= op == 1;
    set_io_bit_instruction <= op == 2;
    clear_io_bit_instruction <= op == 3;
    skip_if_io_bit_set <= op == 4;
    skip_if_io_bit_clear <= op == 5;
    @(posedge clk);
    {io_we, io_rd, set_io_bit_instruction, clear_io_bit_instruction} <= 4'h0;
    {skip_if_io_bit_set, skip_if_io_bit_clear} <= 2'h0;
    // released lines flip so a stale value never passes for a driven one
    io_addr <= ~a;
    io_wdata <= ~(d & m);
    io_bit <= ~b;
    #1;
    q = io_rdata;
    sk = skip_taken;
  endtask : acc
endmodule : irb_core_model

// ===== dv/tb_io_register_space_bit_access.sv
/*
  tb_io_register_space_bit_access: self-checking bench; a shadow copy of
  the 64 bytes predicts reads, skips and pin outputs.
  assumes: irb_pkg, irb_io_regs and irb_core_model are compiled first.
*/
`timescale 1ns/100ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_io_register_space_bit_access;
  import irb_pkg::*;
  // {offset, plain writable, write-one-to-clear}; reserved offsets left out
  localparam logic [23:0] TAB [15] = '{24'h01_0f00, 24'h02_0f00, 24'h03_0f00, 24'h0c_0200, 24'h11_0001,
    24'h14_0001, 24'h1d_ef10, 24'h1f_8f10, 24'h00_0000, 24'h2a_0027, 24'h2b_2700, 24'h2d_df00,
    24'h31_6f80, 24'h37_0300, 24'h3f_ff00};
  // {flag offset, bit} per event input
  localparam logic [8:0] EVT [10] = '{{6'h11, 3'h0}, {6'h14, 3'h0}, {6'h1d, 3'h4}, {6'h1f, 3'h4},
    {6'h2a, 3'h0}, {6'h2a, 3'h1}, {6'h2a, 3'h2}, {6'h2a, 3'h5}, {6'h31, 3'h7}, {6'h34, 3'h7}};
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [9:0]  evt = 10'h000;
  logic [3:0]  pin_in = 4'h0;
  logic [7:0]  conv_result = 8'h00;
  logic        comp_level = 1'b0;
  logic        nvm_busy = 1'b0;
  logic [5:0]  io_addr;
  logic [7:0]  io_wdata, io_rdata;
  logic [2:0]  io_bit;
  logic        io_we, io_rd, set_io_bit_instruction, clear_io_bit_instruction;
  logic        skip_if_io_bit_set, skip_if_io_bit_clear, skip_taken, ext_clk_enable;
  logic [3:0]  pin_dir, pin_out, pin_pullup;
  logic [1:0]  clk_source_sel;
  logic [15:0] r = 16'hb59d;
  logic [7:0]  sh [64] = '{default: 8'h00};
  logic [7:0]  rwm [64] = '{default: 8'h00};
  logic [7:0]  w1m [64] = '{default: 8'h00};
  int          errors = 0;
  int          n_tests = 0;

  always #5 clk = ~clk;

  irb_io_regs irb_io_regs_i (
    .clk, .rst, .io_addr, .io_wdata, .io_we, .io_rd, .set_io_bit_instruction, .clear_io_bit_instruction,
    .skip_if_io_bit_set, .skip_if_io_bit_clear, .io_bit, .pin_in, .pin_change_evt(evt[0]), .ext_irq_evt(evt[1]),
    .conv_done_evt(evt[2]), .comp_evt(evt[3]), .timer_ovf_evt(evt[4]), .timer_cmpa_evt(evt[5]),
    .timer_cmpb_evt(evt[6]), .timer_cap_evt(evt[7]), .watchdog_evt(evt[8]), .supply_evt(evt[9]),
    .conv_result, .comp_level, .nvm_busy, .io_rdata, .skip_taken, .pin_dir, .pin_out, .pin_pullup,
    .clk_source_sel, .ext_clk_enable);
  irb_core_model irb_core_model_i (
    .clk, .io_rdata, .skip_taken, .io_addr, .io_wdata, .io_we, .io_rd, .set_io_bit_instruction,
    .clear_io_bit_instruction, .skip_if_io_bit_set, .skip_if_io_bit_clear, .io_bit);

  function automatic logic [15:0] lfsr(logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr

  // stored byte plus the live inputs that show through
  function automatic logic [7:0] exp_rd(logic [5:0] a);
    logic [7:0] e;
    e = sh[a];
    if (a == ADR_PIN_IN) e = {4'h0, pin_in};
    if (a == ADR_CNV_RES) e = conv_result;
    if (a == ADR_CMP_CS) e[LVL_CMP] = comp_level;
    if (a == ADR_NVM_CS) e[LVL_NVM] = nvm_busy;
    return e;
  endfunction : exp_rd

  task automatic give_verdict();
    if (errors == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : give_verdict

  // one access, then the shadow follows what the register space should do
  task automatic do_op(input int op, input logic [5:0] a, input logic [7:0] d, input logic [2:0] b);
    logic [7:0] q, e, md, one;
    logic       sk;
    e = exp_rd(a);
    md = d & (rwm[a] | w1m[a]);
    one = 8'h01 << b;
    irb_core_model_i.acc(op, a, d, rwm[a] | w1m[a], b, q, sk);
    case (op)
      0: sh[a] = (sh[a] & ~rwm[a] & ~(md & w1m[a])) | (md & rwm[a]);
      1: `CHK(q, e)
      2: if (a <= BIT_TOP) sh[a] = |(one & w1m[a]) ? sh[a] & ~one : sh[a] | (one & rwm[a]);
      3: if (a <= BIT_TOP) sh[a] = sh[a] & ~(one & rwm[a]);
      default: `CHK(sk, (a <= BIT_TOP) && (e[b] == (op == 4)))
    endcase
  endtask : do_op

  // event pulses for one cycle, with the bus idle or alongside an access
  task automatic pulse(input logic [9:0] m);
    @(posedge clk);
    evt <= m;
    @(posedge clk);
    evt <= 10'h000;
    for (int i = 0; i < 10; i++) if (m[i]) sh[EVT[i][8:3]][EVT[i][2:0]] = 1'b1;
  endtask : pulse

  task automatic sweep();
    for (int a = 0; a < 64; a++) do_op(1, 6'(a), 8'h00, 3'h0);
    `CHK({pin_dir, pin_out, pin_pullup}, {sh[1][3:0], sh[2][3:0], sh[3][3:0]})
    `CHK({clk_source_sel, ext_clk_enable}, {sh[ADR_CLK_SEL][1:0], sh[ADR_CLK_SEL][1:0] == CLK_SRC_EXT})
  endtask : sweep

  task automatic do_reset();
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    #1 `CHK(ext_clk_enable, 1'b0)
    @(posedge clk);
    rst <= 1'b0;
    foreach (sh[i]) sh[i] = 8'h00;
    repeat (3) @(posedge clk);
    #1 `CHK(clk_source_sel, CLK_SRC_INT)
  endtask : do_reset

  initial begin
    foreach (TAB[i]) begin
      rwm[TAB[i][21:16]] = TAB[i][15:8];
      w1m[TAB[i][21:16]] = TAB[i][7:0];
    end
    do_reset();
    r = lfsr(r);
    @(posedge clk);
    pin_in <= r[3:0];
    conv_result <= r[15:8];
    comp_level <= r[4];
    nvm_busy <= r[5];
    pulse(10'h3ff);
    do_op(2, ADR_CNV_CS, 8'h00, 3'h0);
    do_op(3, ADR_CNV_CS, 8'h00, 3'(FLG_CNV));
    do_op(4, ADR_EX_FLG, 8'h00, 3'(FLG_EX));
    do_op(0, ADR_PC_FLG, 8'h00, 3'h0);
    do_op(2, ADR_PC_FLG, 8'h00, 3'(FLG_PC));
    do_op(0, ADR_TM_FLG, 8'h05, 3'h0);
    do_op(2, ADR_TM_MSK, 8'h00, 3'h1);
    do_op(5, ADR_TM_MSK, 8'h00, 3'h3);
    // flag event and write-one clear land on one edge: the event must win
    fork
      do_op(0, ADR_PC_FLG, 8'h01, 3'h0);
      pulse(10'h001);
    join
    sh[ADR_PC_FLG][FLG_PC] = 1'b1;
    do_op(1, ADR_PC_FLG, 8'h00, 3'h0);
    sweep();
    // random traffic over listed offsets, with flag events now and then
    for (int i = 0; i < 400; i++) begin
      r = lfsr(r);
      do_op(r[2:0] % 6, TAB[r[6:3] % 15][21:16], r[15:8], r[10:8]);
      if (i % 64 == 63) pulse(r[9:0]);
    end
    sweep();
    do_op(0, ADR_CLK_SEL, {6'h00, CLK_SRC_EXT}, 3'h0);
    sweep();
    do_reset();
    sweep();
    give_verdict();
  end

  // hang guard, well beyond the expected run
  initial begin
    #100000;
    errors++;
    give_verdict();
  end
endmodule : tb_io_register_space_bit_access

// ===== src/irb_io_regs.sv
/*
  irb_io_regs: the 64-byte i/o register space of a small 8-bit
  controller, with byte access and single-bit set, clear and test.
  assumes: the core drives at most one access per cycle and keeps the
  bus signals in its own clock domain; pins arrive asynchronously.
*/
// Overview of operation
// - reset selects internal 8 MHz clock source
// - external clock is gated off during reset
// - bit set and clear on offsets 0x00-0x1F
// - bit skip tests read one selected bit
// - writing one clears flags, zero keeps them
// - bit instructions touch only the addressed bit
// - offsets above 0x1F take byte access only
`timescale 1ns/100ps
module irb_io_regs (
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic [irb_pkg::ADDR_W-1:0]  io_addr,
  input  wire logic [irb_pkg::DATA_W-1:0]  io_wdata,
  input  wire logic                        io_we,
  input  wire logic                        io_rd,
  input  wire logic                        set_io_bit_instruction,
  input  wire logic                        clear_io_bit_instruction,
  input  wire logic                        skip_if_io_bit_set,
  input  wire logic                        skip_if_io_bit_clear,
  input  wire logic [2:0]                  io_bit,
  input  wire logic [3:0]                  pin_in,
  input  wire logic                        pin_change_evt,
  input  wire logic                        ext_irq_evt,
  input  wire logic                        conv_done_evt,
  input  wire logic                        comp_evt,
  input  wire logic                        timer_ovf_evt,
  input  wire logic                        timer_cmpa_evt,
  input  wire logic                        timer_cmpb_evt,
  input  wire logic                        timer_cap_evt,
  input  wire logic                        watchdog_evt,
  input  wire logic                        supply_evt,
  input  wire logic [7:0]                  conv_result,
  input  wire logic                        comp_level,
  input  wire logic                        nvm_busy,
  output logic      [irb_pkg::DATA_W-1:0]  io_rdata,
  output logic                             skip_taken,
  output logic      [3:0]                  pin_dir,
  output logic      [3:0]                  pin_out,
  output logic      [3:0]                  pin_pullup,
  output logic      [1:0]                  clk_source_sel,
  output logic                             ext_clk_enable
);
  import irb_pkg::*;

  logic [7:0] regs_reg  [0:63];
  logic [7:0] regs_next [0:63];
  logic [7:0] set_vec   [0:63];
  logic [3:0] pin_meta_reg;
  logic [3:0] pin_sync_reg;
  logic [7:0] rdata_reg;
  logic       skip_reg;
  logic [7:0] rd_cur;
  logic       bit_ok;
  logic       tst_bit;

  // pins cross into the core clock through two flops
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_meta_reg <= 4'h0;
      pin_sync_reg <= 4'h0;
    end else begin
      pin_meta_reg <= pin_in;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // bit instructions are honoured only in the low half of the space
  assign bit_ok = (io_addr <= BIT_TOP);

  // hardware flag sets, one vector per offset
  always_comb begin
    for (int i = 0; i < 64; i++) begin
      set_vec[i] = 8'h00;
    end
    set_vec[ADR_PC_FLG][FLG_PC]   = pin_change_evt;
    set_vec[ADR_EX_FLG][FLG_EX]   = ext_irq_evt;
    set_vec[ADR_CNV_CS][FLG_CNV]  = conv_done_evt;
    set_vec[ADR_CMP_CS][FLG_CMP]  = comp_evt;
    set_vec[ADR_TM_FLG][FLG_TOVF] = timer_ovf_evt;
    set_vec[ADR_TM_FLG][FLG_TCA]  = timer_cmpa_evt;
    set_vec[ADR_TM_FLG][FLG_TCB]  = timer_cmpb_evt;
    set_vec[ADR_TM_FLG][FLG_TCAP] = timer_cap_evt;
    set_vec[ADR_WDG_CS][FLG_WDG]  = watchdog_evt;
    set_vec[ADR_SUP_CS][FLG_SUP]  = supply_evt;
  end

  // next value of every register: byte write, then bit op, then set
  always_comb begin
    logic [7:0]  n;
    logic [7:0]  wm;
    logic [7:0]  cm;
    logic [7:0]  bm;
    logic [23:0] mk;
    logic        hit;
    n   = 8'h00;
    wm  = 8'h00;
    cm  = 8'h00;
    bm  = 8'h00;
    mk  = 24'h00_0000;
    hit = 1'b0;
    for (int i = 0; i < 64; i++) begin
      n   = regs_reg[i];
      mk  = irb_masks(6'(i));
      wm  = mk[15:8];
      cm  = mk[7:0];
      hit = (io_addr == 6'(i));
      bm  = 8'h01 << io_bit;
      if (io_we && hit) begin
        // reserved offsets have empty masks, so stray writes do nothing
        n = (n & ~wm) | (io_wdata & wm);
        n = n & ~(io_wdata & cm);
      end else if (set_io_bit_instruction && hit && bit_ok) begin
        // only the addressed bit sees a one: a set on a flag clears it
        n = (n | (bm & wm)) & ~(bm & cm);
      end else if (clear_io_bit_instruction && hit && bit_ok) begin
        // a clear writes zero to one bit and leaves flags alone
        n = n & ~(bm & wm);
      end
      // an event in the clearing cycle still lands
      regs_next[i] = n | set_vec[i];
    end
  end

  // register storage; reset also puts the clock back on internal
  always_ff @(posedge clk) begin
    for (int i = 0; i < 64; i++) begin
      if (rst) begin
        regs_reg[i] <= RST_VAL;
      end else begin
        regs_reg[i] <= regs_next[i];
      end
    end
  end

  // read view: stored bits masked, live inputs overlaid
  always_comb begin
    logic [23:0] mk;
    mk     = irb_masks(io_addr);
    rd_cur = regs_reg[io_addr] & mk[23:16];
    unique case (io_addr)
      ADR_PIN_IN:  rd_cur = {4'h0, pin_sync_reg};
      ADR_CNV_RES: rd_cur = conv_result;
      ADR_CMP_CS:  rd_cur[LVL_CMP] = comp_level;
      ADR_NVM_CS:  rd_cur[LVL_NVM] = nvm_busy;
      default:     rd_cur = regs_reg[io_addr] & mk[23:16];
    endcase
  end

  // read data held until the next read
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_reg <= 8'h00;
    end else if (io_rd) begin
      rdata_reg <= rd_cur;
    end
  end

  // skip decision from one bit of the low half
  assign tst_bit = rd_cur[io_bit];
  always_ff @(posedge clk) begin
    if (rst) begin
      skip_reg <= 1'b0;
    end else begin
      skip_reg <= bit_ok && ((skip_if_io_bit_set && tst_bit) ||
                  (skip_if_io_bit_clear && !tst_bit));
    end
  end

  assign io_rdata       = rdata_reg;
  assign skip_taken     = skip_reg;
  assign pin_dir        = regs_reg[ADR_PIN_DIR][3:0];
  assign pin_out        = regs_reg[ADR_PIN_OUT][3:0];
  assign pin_pullup     = regs_reg[ADR_PIN_PUP][3:0];
  assign clk_source_sel = regs_reg[ADR_CLK_SEL][1:0];
  // gated by reset itself, so an external clock cannot leak in
  assign ext_clk_enable = !rst && (clk_source_sel == CLK_SRC_EXT);

  // helper views for the checks
  logic [7:0] chk_dir;
  logic [7:0] chk_stat;
  logic [7:0] chk_cnv;
  logic       chk_pcf;
  logic [7:0] chk_wdg;
  assign chk_dir  = regs_reg[ADR_PIN_DIR];
  assign chk_stat = regs_reg[ADR_PSTAT];
  assign chk_cnv  = regs_reg[ADR_CNV_CS];
  assign chk_pcf  = regs_reg[ADR_PC_FLG][FLG_PC];
  assign chk_wdg  = regs_reg[ADR_WDG_CS];

  property p_clk_int_after_rst;
    @(posedge clk) rst |=> (clk_source_sel == CLK_SRC_INT);
  endproperty
  a_clk_int_after_rst: assert property (p_clk_int_after_rst)
    else $error("clock source not internal after reset");

  property p_no_ext_in_rst;
    @(posedge clk) rst |-> !ext_clk_enable;
  endproperty
  a_no_ext_in_rst: assert property (p_no_ext_in_rst)
    else $error("external clock enabled during reset");

  property p_bit_set_dir;
    @(posedge clk) disable iff (rst)
      (set_io_bit_instruction && !io_we && io_addr == ADR_PIN_DIR && io_bit < 3'h4)
      |=> chk_dir[$past(io_bit)];
  endproperty
  a_bit_set_dir: assert property (p_bit_set_dir)
    else $error("bit set did not reach direction register");

  property p_high_bitop_ignored;
    @(posedge clk) disable iff (rst)
      ((set_io_bit_instruction || clear_io_bit_instruction) && !io_we && io_addr == ADR_PSTAT)
      |=> $stable(chk_stat);
  endproperty
  a_high_bitop_ignored: assert property (p_high_bitop_ignored)
    else $error("bit op changed a high register");

  property p_skip_bit;
    @(posedge clk) disable iff (rst)
      (skip_if_io_bit_set && !skip_if_io_bit_clear && bit_ok)
      |=> (skip_taken == $past(tst_bit));
  endproperty
  a_skip_bit: assert property (p_skip_bit)
    else $error("skip decision does not match tested bit");

  property p_w1c_clear;
    @(posedge clk) disable iff (rst)
      (io_we && io_addr == ADR_PC_FLG && io_wdata[FLG_PC] && !pin_change_evt)
      |=> !chk_pcf;
  endproperty
  a_w1c_clear: assert property (p_w1c_clear)
    else $error("write one did not clear flag");

  property p_w1c_zero_keeps;
    @(posedge clk) disable iff (rst)
      (io_we && io_addr == ADR_PC_FLG && !io_wdata[FLG_PC] && chk_pcf) |=> chk_pcf;
  endproperty
  a_w1c_zero_keeps: assert property (p_w1c_zero_keeps)
    else $error("write zero disturbed flag");

  property p_set_wins;
    @(posedge clk) disable iff (rst)
      (pin_change_evt ##1 !pin_change_evt && !io_we) |-> chk_pcf;
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("flag event lost");

  property p_bitop_keeps_flag;
    @(posedge clk) disable iff (rst)
      ((set_io_bit_instruction || clear_io_bit_instruction) && !io_we &&
       io_addr == ADR_CNV_CS && io_bit != 3'h4 && chk_cnv[FLG_CNV])
      |=> chk_cnv[FLG_CNV];
  endproperty
  a_bitop_keeps_flag: assert property (p_bitop_keeps_flag)
    else $error("bit op cleared a neighbouring flag");

  property p_reserved_zero;
    @(posedge clk) disable iff (rst)
      (io_rd && irb_masks(io_addr) == 24'h00_0000) |=> (io_rdata == 8'h00);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved read not zero");

  // finer checks: single-bit reach, skip polarity, byte access above the bit range
  property p_bit_clr_dir;
    @(posedge clk) disable iff (rst)
      (clear_io_bit_instruction && !set_io_bit_instruction && !io_we && io_addr == ADR_PIN_DIR)
      |=> !chk_dir[$past(io_bit)];
  endproperty
  a_bit_clr_dir: assert property (p_bit_clr_dir)
    else $error("bit clear missed direction register");

  property p_bitop_one_bit;
    @(posedge clk) disable iff (rst)
      ((set_io_bit_instruction || clear_io_bit_instruction) && !io_we && io_addr == ADR_PIN_DIR)
      |=> ((chk_dir ^ $past(chk_dir)) & ~(8'h01 << $past(io_bit))) == 8'h00;
  endproperty
  a_bitop_one_bit: assert property (p_bitop_one_bit)
    else $error("bit op changed a neighbouring bit");

  property p_skip_clr_bit;
    @(posedge clk) disable iff (rst)
      (skip_if_io_bit_clear && !skip_if_io_bit_set && bit_ok)
      |=> (skip_taken == !$past(tst_bit));
  endproperty
  a_skip_clr_bit: assert property (p_skip_clr_bit)
    else $error("skip-if-clear decision wrong");

  property p_skip_high_none;
    @(posedge clk) disable iff (rst)
      ((skip_if_io_bit_set || skip_if_io_bit_clear) && !bit_ok) |=> !skip_taken;
  endproperty
  a_skip_high_none: assert property (p_skip_high_none)
    else $error("skip taken on a high register");

  property p_high_byte_write;
    @(posedge clk) disable iff (rst)
      (io_we && io_addr == ADR_PSTAT) |=> (chk_stat == $past(io_wdata));
  endproperty
  a_high_byte_write: assert property (p_high_byte_write)
    else $error("byte write missed a high register");

  property p_high_bitop_keeps_flag;
    @(posedge clk) disable iff (rst)
      ((set_io_bit_instruction || clear_io_bit_instruction) && !io_we && io_addr == ADR_WDG_CS &&
       !watchdog_evt) |=> $stable(chk_wdg);
  endproperty
  a_high_bitop_keeps_flag: assert property (p_high_bitop_keeps_flag)
    else $error("bit op acted above the bit range");

  property p_bitset_clears_flag;
    @(posedge clk) disable iff (rst)
      (set_io_bit_instruction && !io_we && io_addr == ADR_PC_FLG && io_bit == 3'(FLG_PC) &&
       !pin_change_evt) |=> !chk_pcf;
  endproperty
  a_bitset_clears_flag: assert property (p_bitset_clears_flag)
    else $error("bit set on a flag did not clear it");

  property p_bitclr_keeps_flag;
    @(posedge clk) disable iff (rst)
      (clear_io_bit_instruction && !set_io_bit_instruction && !io_we && io_addr == ADR_PC_FLG && chk_pcf)
      |=> chk_pcf;
  endproperty
  a_bitclr_keeps_flag: assert property (p_bitclr_keeps_flag)
    else $error("bit clear disturbed a flag");

  property p_set_beats_clear;
    @(posedge clk) disable iff (rst)
      (pin_change_evt && io_we && io_addr == ADR_PC_FLG) |=> chk_pcf;
  endproperty
  a_set_beats_clear: assert property (p_set_beats_clear)
    else $error("clear won over a flag event");

  property p_cnv_w1c;
    @(posedge clk) disable iff (rst)
      (io_we && io_addr == ADR_CNV_CS && io_wdata[FLG_CNV] && !conv_done_evt) |=> !chk_cnv[FLG_CNV];
  endproperty
  a_cnv_w1c: assert property (p_cnv_w1c)
    else $error("write one did not clear converter flag");

  property p_dir_byte_write;
    @(posedge clk) disable iff (rst)
      (io_we && io_addr == ADR_PIN_DIR) |=> (chk_dir == ($past(io_wdata) & 8'h0f));
  endproperty
  a_dir_byte_write: assert property (p_dir_byte_write)
    else $error("byte write missed direction register");

  property p_dir_read;
    @(posedge clk) disable iff (rst)
      (io_rd && io_addr == ADR_PIN_DIR) |=> (io_rdata == $past(chk_dir));
  endproperty
  a_dir_read: assert property (p_dir_read)
    else $error("direction read returned other data");

  property p_ext_clk_on_select;
    @(posedge clk) disable iff (rst)
      (io_we && io_addr == ADR_CLK_SEL && io_wdata[1:0] == CLK_SRC_EXT) |=> ext_clk_enable;
  endproperty
  a_ext_clk_on_select: assert property (p_ext_clk_on_select)
    else $error("external clock not enabled when selected");

  c_flag_clear: cover property (@(posedge clk) disable iff (rst)
    chk_pcf ##1 (io_we && io_addr == ADR_PC_FLG) ##1 !chk_pcf);
  c_skip: cover property (@(posedge clk) disable iff (rst) skip_taken);
  c_set_clear: cover property (@(posedge clk) disable iff (rst)
    pin_change_evt && io_we && io_addr == ADR_PC_FLG);
  c_ext_clk: cover property (@(posedge clk) disable iff (rst) ext_clk_enable);
  c_bit_set: cover property (@(posedge clk) disable iff (rst)
    set_io_bit_instruction && bit_ok);

endmodule : irb_io_regs

// ===== src/irb_pkg.sv
/*
  irb_pkg: offsets, bit positions, reset values and the per-offset
  field masks of the 64-byte i/o register space.
  assumes: one package shared by the register bank and its bench.
*/
package irb_pkg;

  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;
  localparam logic [5:0] BIT_TOP = 6'h1f; // last bit-accessible offset

  // register offsets
  localparam logic [5:0] ADR_PIN_IN   = 6'h00;
  localparam logic [5:0] ADR_PIN_DIR  = 6'h01;
  localparam logic [5:0] ADR_PIN_OUT  = 6'h02;
  localparam logic [5:0] ADR_PIN_PUP  = 6'h03;
  localparam logic [5:0] ADR_PORT_CTL = 6'h0c;
  localparam logic [5:0] ADR_PC_MSK   = 6'h10;
  localparam logic [5:0] ADR_PC_FLG   = 6'h11;
  localparam logic [5:0] ADR_PC_CTL   = 6'h12;
  localparam logic [5:0] ADR_EX_MSK   = 6'h13;
  localparam logic [5:0] ADR_EX_FLG   = 6'h14;
  localparam logic [5:0] ADR_EX_SNS   = 6'h15;
  localparam logic [5:0] ADR_DIN_DIS  = 6'h17;
  localparam logic [5:0] ADR_CNV_RES  = 6'h19;
  localparam logic [5:0] ADR_CNV_CH   = 6'h1b;
  localparam logic [5:0] ADR_CNV_TRG  = 6'h1c;
  localparam logic [5:0] ADR_CNV_CS   = 6'h1d;
  localparam logic [5:0] ADR_CMP_CS   = 6'h1f;
  localparam logic [5:0] ADR_TM_CAPL  = 6'h22;
  localparam logic [5:0] ADR_TM_CAPH  = 6'h23;
  localparam logic [5:0] ADR_TM_CBL   = 6'h24;
  localparam logic [5:0] ADR_TM_CBH   = 6'h25;
  localparam logic [5:0] ADR_TM_CAL   = 6'h26;
  localparam logic [5:0] ADR_TM_CAH   = 6'h27;
  localparam logic [5:0] ADR_TM_CNTL  = 6'h28;
  localparam logic [5:0] ADR_TM_CNTH  = 6'h29;
  localparam logic [5:0] ADR_TM_FLG   = 6'h2a;
  localparam logic [5:0] ADR_TM_MSK   = 6'h2b;
  localparam logic [5:0] ADR_TM_FRC   = 6'h2c;
  localparam logic [5:0] ADR_TM_CTB   = 6'h2d;
  localparam logic [5:0] ADR_TM_CTA   = 6'h2e;
  localparam logic [5:0] ADR_TM_GLB   = 6'h2f;
  localparam logic [5:0] ADR_WDG_CS   = 6'h31;
  localparam logic [5:0] ADR_NVM_CS   = 6'h32;
  localparam logic [5:0] ADR_NVM_CMD  = 6'h33;
  localparam logic [5:0] ADR_SUP_CS   = 6'h34;
  localparam logic [5:0] ADR_PWR_RED  = 6'h35;
  localparam logic [5:0] ADR_CLK_PSC  = 6'h36;
  localparam logic [5:0] ADR_CLK_SEL  = 6'h37;
  localparam logic [5:0] ADR_OSC_CAL  = 6'h39;
  localparam logic [5:0] ADR_SLEEP    = 6'h3a;
  localparam logic [5:0] ADR_RST_CAU  = 6'h3b;
  localparam logic [5:0] ADR_CFG_PROT = 6'h3c;
  localparam logic [5:0] ADR_SP_LO    = 6'h3d;
  localparam logic [5:0] ADR_SP_HI    = 6'h3e;
  localparam logic [5:0] ADR_PSTAT    = 6'h3f;

  // hardware-set flag and live level positions
  localparam int FLG_PC   = 0;
  localparam int FLG_EX   = 0;
  localparam int FLG_CNV  = 4;
  localparam int FLG_CMP  = 4;
  localparam int LVL_CMP  = 5;
  localparam int FLG_WDG  = 7;
  localparam int FLG_SUP  = 7;
  localparam int LVL_NVM  = 7;
  localparam int FLG_TOVF = 0;
  localparam int FLG_TCA  = 1;
  localparam int FLG_TCB  = 2;
  localparam int FLG_TCAP = 5;

  // clock source codes; internal oscillator is the reset choice
  localparam logic [1:0] CLK_SRC_INT = 2'h0;
  localparam logic [1:0] CLK_SRC_EXT = 2'h2;
  localparam logic [7:0] RST_VAL     = 8'h00;

  // {readable, plain writable, write-one-to-clear} per offset
  function automatic logic [23:0] irb_masks(logic [5:0] a);
    logic [23:0] m;
    m = 24'h00_0000;
    unique case (a)
      ADR_PIN_IN:   m = {8'h0f, 8'h00, 8'h00};
      ADR_PIN_DIR, ADR_PIN_OUT, ADR_PIN_PUP, ADR_PC_MSK, ADR_DIN_DIS,
      ADR_CLK_PSC, ADR_SLEEP:
                    m = {8'h0f, 8'h0f, 8'h00};
      ADR_PORT_CTL: m = {8'h02, 8'h02, 8'h00};
      ADR_PC_FLG, ADR_EX_FLG:
                    m = {8'h01, 8'h00, 8'h01};
      ADR_PC_CTL, ADR_EX_MSK:
                    m = {8'h01, 8'h01, 8'h00};
      ADR_EX_SNS, ADR_CNV_CH, ADR_PWR_RED, ADR_CLK_SEL:
                    m = {8'h03, 8'h03, 8'h00};
      ADR_CNV_RES:  m = {8'hff, 8'h00, 8'h00};
      ADR_CNV_TRG:  m = {8'h07, 8'h07, 8'h00};
      ADR_CNV_CS:   m = {8'hff, 8'hef, 8'h10};
      ADR_CMP_CS:   m = {8'hbf, 8'h8f, 8'h10};
      ADR_TM_CAPL, ADR_TM_CAPH, ADR_TM_CBL, ADR_TM_CBH, ADR_TM_CAL,
      ADR_TM_CAH, ADR_TM_CNTL, ADR_TM_CNTH, ADR_OSC_CAL, ADR_SP_LO,
      ADR_SP_HI, ADR_PSTAT:
                    m = {8'hff, 8'hff, 8'h00};
      ADR_TM_FLG:   m = {8'h27, 8'h00, 8'h27};
      ADR_TM_MSK:   m = {8'h27, 8'h27, 8'h00};
      ADR_TM_CTB:   m = {8'hdf, 8'hdf, 8'h00};
      ADR_TM_CTA:   m = {8'hf3, 8'hf3, 8'h00};
      ADR_TM_GLB:   m = {8'h81, 8'h81, 8'h00};
      ADR_WDG_CS:   m = {8'hef, 8'h6f, 8'h80};
      ADR_NVM_CS:   m = {8'h80, 8'h00, 8'h00};
      ADR_NVM_CMD:  m = {8'h3f, 8'h3f, 8'h00};
      ADR_SUP_CS:   m = {8'hc7, 8'h47, 8'h80};
      ADR_RST_CAU:  m = {8'h0b, 8'h0b, 8'h00};
      default:      m = 24'h00_0000; // reserved offsets: nothing readable or writable
    endcase
    return m;
  endfunction : irb_masks

endpackage : irb_pkg
